// File: hdl/capture_compare_timer16.v
// 16-bit capture/compare timer channel with AXI4-Lite register slave
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.vh"

module capture_compare_timer16 #(
   parameter ADDR_W       = 8,
   parameter SYNC_CAPABLE = 1
) (
   input  wire              core_clk,
   input  wire              rst_b,
   input  wire              ce,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output wire [1:0]        s_axi_bresp,
   output wire              s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output wire [31:0]       s_axi_rdata,
   output wire [1:0]        s_axi_rresp,
   output wire              s_axi_rvalid,
   input  wire              s_axi_rready,
   input  wire              master_run_in,
   output wire              start_out,
   input  wire              external_count_input,
   input  wire              capture_input_b,
   input  wire              peer_toggle_in,
   output wire              timer_output_pin,
   output wire              timer_match_irq,
   output wire              capture_irq_a,
   output wire              capture_irq_b
);

// ==========================================================
// bus slave state
reg  [ADDR_W-1:0] aw_addr_r;
reg               aw_full_r;
reg  [31:0]       w_data_r;
reg  [3:0]        w_strb_r;
reg               w_full_r;
reg               bvalid_r;
reg  [1:0]        bresp_r;
reg               rvalid_r;
reg  [31:0]       rdata_r;
reg  [1:0]        rresp_r;

// ==========================================================
// channel state
reg               enable_r;
reg               count_run_r;
reg               pre_run_r;
reg               buf_en_r;
reg               sync_sel_r;
reg  [2:0]        clk_sel_r;
reg               clr_match_r;
reg  [1:0]        cap_sel_r;
reg  [3:0]        tog_en_r;
reg  [15:0]       cmp_a_r;
reg  [15:0]       cmp_b_r;
reg  [15:0]       buf_a_r;
reg  [15:0]       buf_b_r;
reg  [15:0]       cap_a_r;
reg  [15:0]       cap_b_r;
reg  [15:0]       uc_r;
reg               moved_r;
reg  [7:0]        pre_cnt_r;
reg               tff_r;
reg  [4:0]        status_r;
reg               match_irq_r;
reg               cap_irq_a_r;
reg               cap_irq_b_r;
reg  [2:0]        sync1_r;
reg  [2:0]        sync2_r;
reg  [2:0]        sync3_r;

// ==========================================================
// combinational signals
wire              wr_go;
reg  [7:0]        wsel;
reg               wr_map;
reg  [31:0]       rd_val;
reg               rd_map;
reg  [7:0]        pre_mask;
wire              sync_eff;
wire              run_ok;
wire              pre_hit;
wire              cnt_tick;
wire              eq_a;
wire              eq_b;
wire              match_a;
wire              match_b;
wire              ovf;
wire [2:0]        rise;
wire [2:0]        fall;
reg               cap_a_hw;
reg               cap_b_hw;
wire              soft_cap;
wire              cap_a_ev;
wire              cap_b_ev;
wire              tog_ev;
wire              frc_wr;
wire              immediate;
wire              reload;
wire [4:0]        st_set;
wire [4:0]        st_clr;

function [15:0] merge16;
   input [15:0] old;
   input [31:0] d;
   input [3:0]  s;
   begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   end
endfunction

// valid is hidden while frozen so no handshake completes under ce low
assign s_axi_awready = ce & ~aw_full_r & ~bvalid_r;
assign s_axi_wready  = ce & ~w_full_r & ~bvalid_r;
assign s_axi_bvalid  = ce & bvalid_r;
assign s_axi_bresp   = bresp_r;
assign s_axi_arready = ce & ~rvalid_r;
assign s_axi_rvalid  = ce & rvalid_r;
assign s_axi_rdata   = rdata_r;
assign s_axi_rresp   = rresp_r;
assign wr_go         = ce & aw_full_r & w_full_r & ~bvalid_r;

// ==========================================================
// address decode
always @* begin
   wsel   = 8'h00;
   wr_map = 1'b1;
   if (aw_addr_r == `OFS_ENABLE) begin
      wsel[0] = 1'b1;
   end else if (aw_addr_r == `OFS_RUN) begin
      wsel[1] = 1'b1;
   end else if (aw_addr_r == `OFS_CTRL) begin
      wsel[2] = 1'b1;
   end else if (aw_addr_r == `OFS_MODE) begin
      wsel[3] = 1'b1;
   end else if (aw_addr_r == `OFS_TOGGLE) begin
      wsel[4] = 1'b1;
   end else if (aw_addr_r == `OFS_STATUS) begin
      wsel[5] = 1'b1;
   end else if (aw_addr_r == `OFS_CMP_A) begin
      wsel[6] = 1'b1;
   end else if (aw_addr_r == `OFS_CMP_B) begin
      wsel[7] = 1'b1;
   end else if (aw_addr_r == `OFS_CAP_A || aw_addr_r == `OFS_CAP_B ||
                aw_addr_r == `OFS_COUNT) begin
      // read-only registers: write accepted and ignored
      wsel = 8'h00;
   end else begin
      wr_map = 1'b0;
   end
end

always @* begin
   rd_val = 32'h0000_0000;
   rd_map = 1'b1;
   if (s_axi_araddr == `OFS_ENABLE) begin
      rd_val[`EN_BIT] = enable_r;
   end else if (s_axi_araddr == `OFS_RUN) begin
      rd_val[`RUN_CNT_BIT] = count_run_r;
      rd_val[`RUN_PRE_BIT] = pre_run_r;
   end else if (s_axi_araddr == `OFS_CTRL) begin
      rd_val[`CTRL_BUF_BIT]  = buf_en_r;
      rd_val[`CTRL_SYNC_BIT] = sync_sel_r;
   end else if (s_axi_araddr == `OFS_MODE) begin
      rd_val[`MOD_CLK_LSB+2:`MOD_CLK_LSB] = clk_sel_r;
      rd_val[`MOD_CLE_BIT]                = clr_match_r;
      rd_val[`MOD_CPM_LSB+1:`MOD_CPM_LSB] = cap_sel_r;
      rd_val[`MOD_SWCAP_BIT]              = 1'b1;
   end else if (s_axi_araddr == `OFS_TOGGLE) begin
      rd_val[`TOG_FRC_LSB+1:`TOG_FRC_LSB] = 2'h3;
      rd_val[`TOG_EN_LSB+3:`TOG_EN_LSB]   = tog_en_r;
   end else if (s_axi_araddr == `OFS_STATUS) begin
      rd_val[4:0] = status_r;
   end else if (s_axi_araddr == `OFS_CMP_A) begin
      rd_val[15:0] = cmp_a_r;
   end else if (s_axi_araddr == `OFS_CMP_B) begin
      rd_val[15:0] = cmp_b_r;
   end else if (s_axi_araddr == `OFS_CAP_A) begin
      rd_val[15:0] = cap_a_r;
   end else if (s_axi_araddr == `OFS_CAP_B) begin
      rd_val[15:0] = cap_b_r;
   end else if (s_axi_araddr == `OFS_COUNT) begin
      rd_val[15:0] = uc_r;
   end else begin
      rd_map = 1'b0;
   end
end

// ==========================================================
// count source and start
// prescaler tap masks
always @* begin
   case (clk_sel_r)
      3'h1:    pre_mask = 8'h00;
      3'h2:    pre_mask = 8'h03;
      3'h3:    pre_mask = 8'h0F;
      3'h4:    pre_mask = 8'h1F;
      3'h5:    pre_mask = 8'h3F;
      3'h6:    pre_mask = 8'h7F;
      default: pre_mask = 8'hFF;
   endcase
end

assign pre_hit   = pre_run_r & ((pre_cnt_r & pre_mask) == pre_mask);
assign sync_eff  = (SYNC_CAPABLE != 0) & sync_sel_r;
assign run_ok    = enable_r & count_run_r & (sync_eff ? master_run_in : 1'b1);
// only independent channels lead a group
assign start_out = enable_r & count_run_r & ~sync_eff;
assign cnt_tick  = run_ok & ((clk_sel_r == `CLK_EXT) ? rise[0] : pre_hit);

// ==========================================================
// comparison, capture and toggle events
// comparators, checked once per new count
assign eq_a     = (uc_r == cmp_a_r);
assign eq_b     = (uc_r == cmp_b_r);
assign match_a  = enable_r & moved_r & eq_a;
assign match_b  = enable_r & moved_r & eq_b;
assign ovf      = cnt_tick & (uc_r == 16'hFFFF) & ~(clr_match_r & eq_b);
assign rise     = sync2_r & ~sync3_r;
assign fall     = ~sync2_r & sync3_r;

always @* begin
   cap_a_hw = 1'b0;
   cap_b_hw = 1'b0;
   case (cap_sel_r)
      `CPM_PINS: begin
         cap_a_hw = rise[0];
         cap_b_hw = rise[1];
      end
      `CPM_PIN0_EDGE: begin
         cap_a_hw = rise[0];
         cap_b_hw = fall[0];
      end
      `CPM_PEER_EDGE: begin
         cap_a_hw = rise[2];
         cap_b_hw = fall[2];
      end
      default: begin
         cap_a_hw = 1'b0;
         cap_b_hw = 1'b0;
      end
   endcase
end

// zero written to soft capture bit
assign soft_cap  = wr_go & wsel[3] & w_strb_r[0] & ~w_data_r[`MOD_SWCAP_BIT];
assign cap_a_ev  = enable_r & (cap_a_hw | soft_cap);
assign cap_b_ev  = enable_r & cap_b_hw;
assign tog_ev    = ^(tog_en_r & {cap_b_ev, cap_a_ev, match_b, match_a});
assign frc_wr    = wr_go & wsel[4] & w_strb_r[0];
assign immediate = ~(buf_en_r & run_ok);
// buffer transfer on match with compare b
assign reload    = buf_en_r & run_ok & match_b;
assign st_set    = {cap_b_ev, cap_a_ev, ovf, match_b, match_a};
assign st_clr    = (wr_go & wsel[5] & w_strb_r[0]) ? w_data_r[4:0] : 5'h00;

// ==========================================================
// sequential logic
always @(posedge core_clk or negedge rst_b) begin
   if (!rst_b) begin
      aw_addr_r   <= {ADDR_W{1'b0}};
      aw_full_r   <= 1'b0;
      w_data_r    <= 32'h0000_0000;
      w_strb_r    <= 4'h0;
      w_full_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `RESP_OKAY;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      rresp_r     <= `RESP_OKAY;
      enable_r    <= 1'b0;
      count_run_r <= 1'b0;
      pre_run_r   <= 1'b0;
      buf_en_r    <= 1'b0;
      sync_sel_r  <= 1'b0;
      clk_sel_r   <= `CLK_SEL_RST;
      clr_match_r <= 1'b0;
      cap_sel_r   <= `CPM_RST;
      tog_en_r    <= `TOG_EN_RST;
      cmp_a_r     <= `WORD16_RST;
      cmp_b_r     <= `WORD16_RST;
      buf_a_r     <= `WORD16_RST;
      buf_b_r     <= `WORD16_RST;
      cap_a_r     <= `WORD16_RST;
      cap_b_r     <= `WORD16_RST;
      uc_r        <= `WORD16_RST;
      moved_r     <= 1'b0;
      pre_cnt_r   <= `PRE_RST;
      // undefined level, held at low here
      tff_r       <= 1'b0;
      status_r    <= `STATUS_RST;
      match_irq_r <= 1'b0;
      cap_irq_a_r <= 1'b0;
      cap_irq_b_r <= 1'b0;
      sync1_r     <= 3'h0;
      sync2_r     <= 3'h0;
      sync3_r     <= 3'h0;
   end else if (ce) begin
      sync1_r <= {peer_toggle_in, capture_input_b, external_count_input};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (s_axi_awvalid && !aw_full_r && !bvalid_r) begin
         aw_addr_r <= s_axi_awaddr;
         aw_full_r <= 1'b1;
      end
      if (s_axi_wvalid && !w_full_r && !bvalid_r) begin
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
         w_full_r <= 1'b1;
      end
      if (wr_go) begin
         aw_full_r <= 1'b0;
         w_full_r  <= 1'b0;
         bvalid_r  <= 1'b1;
         bresp_r   <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
      if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_val;
         rresp_r  <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
      // control fields live in byte lane 0
      if (wr_go && w_strb_r[0]) begin
         if (wsel[0]) begin
            enable_r <= w_data_r[`EN_BIT];
         end
         if (wsel[1]) begin
            count_run_r <= w_data_r[`RUN_CNT_BIT];
            pre_run_r   <= w_data_r[`RUN_PRE_BIT];
         end
         if (wsel[2]) begin
            buf_en_r   <= w_data_r[`CTRL_BUF_BIT];
            sync_sel_r <= w_data_r[`CTRL_SYNC_BIT] & (SYNC_CAPABLE != 0);
         end
         if (wsel[3]) begin
            clk_sel_r   <= w_data_r[`MOD_CLK_LSB+2:`MOD_CLK_LSB];
            clr_match_r <= w_data_r[`MOD_CLE_BIT];
            cap_sel_r   <= w_data_r[`MOD_CPM_LSB+1:`MOD_CPM_LSB];
         end
         if (wsel[4]) begin
            tog_en_r <= w_data_r[`TOG_EN_LSB+3:`TOG_EN_LSB];
         end
      end
      // compare writes: buffer always, active when immediate
      if (wr_go && wsel[6]) begin
         buf_a_r <= merge16(buf_a_r, w_data_r, w_strb_r);
      end
      if (wr_go && wsel[7]) begin
         buf_b_r <= merge16(buf_b_r, w_data_r, w_strb_r);
      end
      if (wr_go && wsel[6] && immediate) begin
         cmp_a_r <= merge16(cmp_a_r, w_data_r, w_strb_r);
      end else if (reload) begin
         cmp_a_r <= buf_a_r;
      end
      if (wr_go && wsel[7] && immediate) begin
         cmp_b_r <= merge16(cmp_b_r, w_data_r, w_strb_r);
      end else if (reload) begin
         cmp_b_r <= buf_b_r;
      end
      // prescaler free-runs only while its run bit and the channel are on
      if (pre_run_r && enable_r) begin
         pre_cnt_r <= pre_cnt_r + 8'h01;
      end else begin
         pre_cnt_r <= `PRE_RST;
      end
      moved_r <= cnt_tick;
      if (!count_run_r) begin
         uc_r <= `WORD16_RST;
      end else if (cnt_tick) begin
         // clear on compare b gives the period
         if (clr_match_r && eq_b) begin
            uc_r <= `WORD16_RST;
         end else begin
            uc_r <= uc_r + 16'h0001;
         end
      end
      if (cap_a_ev) begin
         cap_a_r <= uc_r;
      end
      if (cap_b_ev) begin
         cap_b_r <= uc_r;
      end
      // force write takes priority over events
      if (frc_wr && w_data_r[`TOG_FRC_LSB+1:`TOG_FRC_LSB] == `FRC_INVERT) begin
         tff_r <= ~tff_r;
      end else if (frc_wr && w_data_r[`TOG_FRC_LSB+1:`TOG_FRC_LSB] == `FRC_SET) begin
         tff_r <= 1'b1;
      end else if (frc_wr && w_data_r[`TOG_FRC_LSB+1:`TOG_FRC_LSB] == `FRC_CLEAR) begin
         tff_r <= 1'b0;
      end else if (tog_ev) begin
         tff_r <= ~tff_r;
      end
      status_r    <= (status_r & ~st_clr) | st_set;
      match_irq_r <= match_a | match_b | ovf;
      cap_irq_a_r <= cap_a_ev;
      cap_irq_b_r <= cap_b_ev;
   end
end

assign timer_output_pin = tff_r;
assign timer_match_irq  = match_irq_r;
assign capture_irq_a    = cap_irq_a_r;
assign capture_irq_b    = cap_irq_b_r;

endmodule // capture_compare_timer16
`default_nettype wire

// File: hdl/timer16_consts.vh
// register map, field positions, codes and reset values of the capture/compare timer
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH
// ==========================================================
// register byte offsets
`define OFS_ENABLE    8'h00
`define OFS_RUN       8'h04
`define OFS_CTRL      8'h08
`define OFS_MODE      8'h0C
`define OFS_TOGGLE    8'h10
`define OFS_STATUS    8'h14
`define OFS_CMP_A     8'h18
`define OFS_CMP_B     8'h1C
`define OFS_CAP_A     8'h20
`define OFS_CAP_B     8'h24
`define OFS_COUNT     8'h28
// ==========================================================
// field positions
`define EN_BIT        7
`define RUN_CNT_BIT   0
`define RUN_PRE_BIT   2
`define CTRL_BUF_BIT  7
`define CTRL_SYNC_BIT 5
`define MOD_CLK_LSB   0
`define MOD_CLE_BIT   3
`define MOD_CPM_LSB   4
`define MOD_SWCAP_BIT 6
`define TOG_FRC_LSB   0
`define TOG_EN_LSB    2
`define ST_MATCH_A    0
`define ST_MATCH_B    1
`define ST_OVF        2
`define ST_CAP_A      3
`define ST_CAP_B      4
// ==========================================================
// codes
`define CLK_EXT       3'h0
`define FRC_INVERT    2'h0
`define FRC_SET       2'h1
`define FRC_CLEAR     2'h2
`define CPM_OFF       2'h0
`define CPM_PINS      2'h1
`define CPM_PIN0_EDGE 2'h2
`define CPM_PEER_EDGE 2'h3
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
// ==========================================================
// reset values
`define WORD16_RST    16'h0000
`define CLK_SEL_RST   3'h0
`define CPM_RST       2'h0
`define TOG_EN_RST    4'h0
`define STATUS_RST    5'h00
`define PRE_RST       8'h00
`endif

// File: verification/timer16_checker_assertions.sv
// concurrent checks on the port behaviour of the timer channel
`timescale 1ns/1ps
`default_nettype none
module timer16_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic master_run_in,
   input wire logic start_out,
   input wire logic timer_output_pin,
   input wire logic timer_match_irq,
   input wire logic capture_irq_a,
   input wire logic capture_irq_b
);
   logic bv_q;
   wire  wr_done = s_axi_bvalid & ~bv_q;
   wire  ev = wr_done | timer_match_irq | capture_irq_a | capture_irq_b;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // a rising bvalid marks the edge at which a register write lands
   always @(posedge core_clk or negedge rst_b)
      if (!rst_b)
         bv_q <= 1'b0;
      else
         bv_q <= s_axi_bvalid;

   // ==========
   // register bus
   // both slots fill at the taking edge, the write lands one edge later with bvalid
   a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready) ##1 ce ##1 ce |-> s_axi_bvalid) else $error("write not answered");
   a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) ##1 ce |-> s_axi_rvalid)
      else $error("read not answered");
   a_resp_holds: assert property (ce && s_axi_bvalid && !s_axi_bready ##1 ce |-> s_axi_bvalid)
      else $error("write response dropped");
   a_read_holds: assert property (ce && s_axi_rvalid && !s_axi_rready ##1 ce |-> s_axi_rvalid)
      else $error("read response dropped");
   a_busy_masks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_ce_masks: assert property (!ce |-> !(s_axi_awready || s_axi_wready || s_axi_arready
      || s_axi_bvalid || s_axi_rvalid)) else $error("bus active while frozen");

   // ==========
   // channel behaviour
   a_start_write: assert property ($changed(start_out) |-> wr_done)
      else $error("start changed without a write");
   a_pin_cause: assert property ($changed(timer_output_pin) |-> ##[0:1] (ev || $past(ev)))
      else $error("output pin changed without cause");
   a_cap_a_pulse: assert property (capture_irq_a |=> !capture_irq_a)
      else $error("capture a interrupt too long");
   a_cap_b_pulse: assert property (capture_irq_b |=> !capture_irq_b)
      else $error("capture b interrupt too long");
   a_stopped_quiet: assert property ((!start_out && !master_run_in)[*8] |-> !timer_match_irq)
      else $error("timer interrupt while stopped");

   c_match: cover property (timer_match_irq);
   c_cap_b: cover property (capture_irq_b);
   c_pin: cover property ($changed(timer_output_pin));
endmodule // timer16_checker

bind capture_compare_timer16 timer16_checker chk_i (.core_clk, .rst_b, .ce,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .master_run_in, .start_out, .timer_output_pin, .timer_match_irq,
   .capture_irq_a, .capture_irq_b);
`default_nettype wire

// File: verification/capture_compare_timer16_bench.sv
// self-checking bench of the capture/compare timer channel
`timescale 1ns/1ps
`default_nettype none
`include "timer16_consts.vh"
module capture_compare_timer16_bench;
   reg         core_clk, rst_b, ce, master_run_in;
   reg         external_count_input, capture_input_b, peer_toggle_in;
   reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg  [7:0]  s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata;
   reg  [3:0]  s_axi_wstrb;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire        start_out, timer_output_pin, timer_match_irq, capture_irq_a, capture_irq_b;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer     seed, miscompares, checks_done, i, k, m, nn, n_a, n_b, n_m, fm, a0, b0;
   reg  [31:0] rd;
   reg  [1:0]  rsp;

   capture_compare_timer16 dut (.core_clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .master_run_in, .start_out, .external_count_input, .capture_input_b,
      .peer_toggle_in, .timer_output_pin, .timer_match_irq, .capture_irq_a,
      .capture_irq_b);

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // event counters have one driver; reset is low from time zero
   always @(posedge core_clk) begin
      if (!rst_b) begin
         n_a <= 0;
         n_b <= 0;
         n_m <= 0;
      end else begin
         n_a <= n_a + capture_irq_a;
         n_b <= n_b + capture_irq_b;
         n_m <= n_m + timer_match_irq;
      end
   end

   // ==========
   // tasks
   task results;
      begin
         $display("checks %0d mismatches %0d", checks_done, miscompares);
         if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   task chk(input [8*10:1] nm, input [31:0] s, input [31:0] e);
      begin
         checks_done = checks_done + 1;
         if (s !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value %0s expected %h seen %h", nm, e, s);
         end
      end
   endtask

   // handshakes are sampled at the falling edge, where pre-edge values sit settled
   task bus(input w, input [7:0] a, input [31:0] d);
      integer n, st;
      reg     ah, wh, arh, fin;
      begin
         @(posedge core_clk);
         st = {$random(seed)} % 4;
         fin = 1'b0;
         if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
         end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
         end
         for (n = 0; n < 60 && fin !== 1'b1; n = n + 1) begin
            @(negedge core_clk);
            ah = s_axi_awvalid & s_axi_awready;
            wh = s_axi_wvalid & s_axi_wready;
            arh = s_axi_arvalid & s_axi_arready;
            fin = w ? s_axi_bvalid & s_axi_bready : s_axi_rvalid & s_axi_rready;
            rd = s_axi_rdata;
            rsp = w ? s_axi_bresp : s_axi_rresp;
            @(posedge core_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (arh) s_axi_arvalid <= 1'b0;
            if (st > 0) st = st - 1;
            else begin
               s_axi_bready <= w & !fin;
               s_axi_rready <= !w & !fin;
            end
         end
         if (fin !== 1'b1) begin
            miscompares = miscompares + 1;
            results;
         end
      end
   endtask

   task rdc(input [7:0] a, input [31:0] e, input [8*10:1] nm);
      begin
         bus(1'b0, a, 32'h0);
         chk(nm, {16'h0, rd[15:0]}, e);
      end
   endtask

   task pls(input [2:0] p);
      begin
         @(posedge core_clk);
         {peer_toggle_in, capture_input_b, external_count_input} <= p;
         repeat (5) @(posedge core_clk);
         {peer_toggle_in, capture_input_b, external_count_input} <= 3'h0;
         repeat (5) @(posedge core_clk);
      end
   endtask

   task wirq;
      begin
         k = 0;
         @(negedge core_clk);
         while (timer_match_irq !== 1'b1 && k < 1100) begin
            k = k + 1;
            @(negedge core_clk);
         end
         if (k >= 1100) begin
            miscompares = miscompares + 1;
            results;
         end
      end
   endtask

   // ==========
   // main sequence
   initial begin
      seed = 95619;
      {miscompares, checks_done, fm} = 0;
      {rst_b, master_run_in, external_count_input, capture_input_b, peer_toggle_in} = 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      ce = 1'b1;
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      rdc(`OFS_CTRL, 32'h0, "ctrl");
      rdc(`OFS_COUNT, 32'h0, "count");
      bus(1'b1, 8'h3C, 32'h0);
      chk("bresp", rsp, `RESP_SLVERR);
      bus(1'b0, 8'h3C, 32'h0);
      chk("rresp", rsp, `RESP_SLVERR);
      $display("done: reset and refusals");
      bus(1'b1, `OFS_ENABLE, 32'h80);
      bus(1'b1, `OFS_TOGGLE, 32'h13);
      bus(1'b1, `OFS_MODE, 32'h40);
      bus(1'b1, `OFS_RUN, 32'h1);
      chk("start", start_out, 1);
      k = 3 + {$random(seed)} % 6;
      repeat (k) pls(3'h1);
      rdc(`OFS_COUNT, k, "count");
      bus(1'b1, `OFS_MODE, 32'h0);
      fm = 1;
      rdc(`OFS_CAP_A, k, "cap a");
      chk("cap a irq", n_a, 1);
      chk("flop", timer_output_pin, fm);
      rdc(`OFS_STATUS, 32'h8, "status");
      for (i = 0; i < 3; i = i + 1) begin
         m = i == 0 ? `FRC_CLEAR : i == 1 ? `FRC_SET : `FRC_INVERT;
         fm = m == `FRC_SET ? 1 : m == `FRC_CLEAR ? 0 : 1 - fm;
         bus(1'b1, `OFS_TOGGLE, m);
         chk("flop", timer_output_pin, fm);
      end
      $display("done: event count, soft capture, flop");
      for (i = 0; i < 4; i = i + 1) begin
         bus(1'b1, `OFS_MODE, 32'h40 | (i << 4));
         a0 = n_a;
         b0 = n_b;
         pls(3'h2);
         pls(3'h4);
         chk("cap a irq", n_a - a0, i == 3);
         chk("cap b irq", n_b - b0, i % 2);
      end
      rdc(`OFS_CAP_B, k, "cap b");
      bus(1'b1, `OFS_RUN, 32'h0);
      rdc(`OFS_COUNT, 32'h0, "count");
      $display("done: capture selects, stop");
      bus(1'b1, `OFS_CTRL, 32'h80);
      bus(1'b1, `OFS_CMP_A, 32'h2);
      rdc(`OFS_CMP_A, 32'h2, "cmp a");
      // pulse setup keeps compare a below compare b
      bus(1'b1, `OFS_CMP_B, 32'h4);
      bus(1'b1, `OFS_MODE, 32'h48);
      bus(1'b1, `OFS_RUN, 32'h1);
      bus(1'b1, `OFS_CMP_A, 32'h3);
      rdc(`OFS_CMP_A, 32'h2, "cmp a");
      m = n_m;
      repeat (4) pls(3'h1);
      rdc(`OFS_CMP_A, 32'h3, "cmp a");
      chk("match irq", n_m - m, 2);
      rdc(`OFS_COUNT, 32'h4, "count");
      pls(3'h1);
      rdc(`OFS_COUNT, 32'h0, "count");
      $display("done: compare buffering");
      bus(1'b1, `OFS_CTRL, 32'h0);
      nn = 1 + {$random(seed)} % 3;
      bus(1'b1, `OFS_CMP_A, nn);
      bus(1'b1, `OFS_CMP_B, nn);
      for (i = 1; i < 8; i = i + 1) begin
         bus(1'b1, `OFS_RUN, 32'h0);
         bus(1'b1, `OFS_MODE, 32'h48 | i);
         bus(1'b1, `OFS_RUN, 32'h5);
         wirq;
         wirq;
         chk("period", k + 1, (nn + 1) * (i == 1 ? 1 : i == 2 ? 4 : 1 << (i + 1)));
      end
      $display("done: interval periods");
      bus(1'b1, `OFS_RUN, 32'h0);
      bus(1'b1, `OFS_CMP_A, 32'h0);
      bus(1'b1, `OFS_CMP_B, 32'h0);
      bus(1'b1, `OFS_MODE, 32'h41);
      bus(1'b1, `OFS_STATUS, 32'h1F);
      bus(1'b1, `OFS_RUN, 32'h5);
      // one full wrap of the sixteen-bit count at one tick a clock
      repeat (65560) @(posedge core_clk);
      rdc(`OFS_STATUS, 32'h7, "status");
      bus(1'b1, `OFS_ENABLE, 32'h0);
      chk("start", start_out, 0);
      bus(1'b0, `OFS_COUNT, 32'h0);
      m = rd[15:0];
      ce <= 1'b0;
      repeat (20) @(posedge core_clk);
      ce <= 1'b1;
      rdc(`OFS_COUNT, m, "count");
      bus(1'b1, `OFS_ENABLE, 32'h80);
      bus(1'b1, `OFS_RUN, 32'h0);
      bus(1'b1, `OFS_CTRL, 32'h20);
      bus(1'b1, `OFS_RUN, 32'h5);
      repeat (20) @(posedge core_clk);
      chk("start", start_out, 0);
      rdc(`OFS_COUNT, 32'h0, "count");
      master_run_in <= 1'b1;
      repeat (10) @(posedge core_clk);
      bus(1'b0, `OFS_COUNT, 32'h0);
      chk("counting", rd[15:0] > 16'h0, 1);
      $display("done: overflow, enable, sync");
      results;
   end
endmodule // capture_compare_timer16_bench
`default_nettype wire
